// [src/cteu_consts.svh]
`ifndef CTEU_CONSTS_SVH
`define CTEU_CONSTS_SVH
// status word flag positions
`define CTEU_PSW_ID_BIT 5
`define CTEU_PSW_EP_BIT 6
`define CTEU_PSW_NP_BIT 7
`define CTEU_PSW_RESET 32'h00000020
// handler addresses
`define CTEU_SWX_HANDLER_LO 32'h00000040
`define CTEU_SWX_HANDLER_HI 32'h00000050
`define CTEU_DBG_HANDLER 32'h00000060
// vector range split
`define CTEU_VEC_SPLIT_BIT 4
// cause code base for software exceptions, vector added in low bits
`define CTEU_SWX_CODE_BASE 16'h0040
`define CTEU_ILG_CODE 16'h0060
// illegal opcode encoding
`define CTEU_ILG_OP_VAL 6'h3F
`define CTEU_ILG_SUB_MIN 4'h7
`endif

// [src/cteu_pkg.sv]
package cteu_pkg;
    typedef enum logic [2:0] {
        CTEU_EV_NONE,
        CTEU_EV_SWX,
        CTEU_EV_ILG,
        CTEU_EV_DBT,
        CTEU_EV_EXCEPTION_RETURN_INSN,
        CTEU_EV_DEBUG_RETURN_INSN
    } cteu_event_type;
endpackage

// [src/cteu_decode.sv]
`timescale 1ns/1ps
`include "cteu_consts.svh"
module cteu_decode
    import cteu_pkg::*;
(
    // instruction strobes from the decoder
    input wire logic insn_valid,
    input wire logic [31:0] insn_word,
    input wire logic trap_insn,
    input wire logic debug_trap_insn,
    input wire logic exception_return_insn,
    input wire logic debug_return_insn,
    // classified event
    output logic is_illegal,
    output cteu_event_type event_kind
);
    always_comb begin
        is_illegal = (insn_word[10:5] == `CTEU_ILG_OP_VAL)
            && (insn_word[26:23] >= `CTEU_ILG_SUB_MIN)
            && !insn_word[16];
        event_kind = CTEU_EV_NONE;
        if (insn_valid) begin
            // illegal decode outranks any strobe on the same word
            if (is_illegal) begin
                event_kind = CTEU_EV_ILG;
            end else if (debug_trap_insn) begin
                event_kind = CTEU_EV_DBT;
            end else if (trap_insn) begin
                event_kind = CTEU_EV_SWX;
            end else if (debug_return_insn) begin
                event_kind = CTEU_EV_DEBUG_RETURN_INSN;
            end else if (exception_return_insn) begin
                event_kind = CTEU_EV_EXCEPTION_RETURN_INSN;
            end
        end
    end
endmodule

// [src/cteu_unit.sv]
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "cteu_consts.svh"
// Summary of operation
// - trap instruction raises a software exception unless an illegal word or a debug trap outranks it; vector 00H..1FH.
// - software exception saves return PC and status into exception save registers.
// - software exception writes cause code into low 16 bits of cause register.
// - software exception sets exception-pending and irq-disable flags.
// - handler 40H for vectors 00H..0FH, 50H for 10H..1FH.
// - exception return with pending flag set restores from exception save registers.
// - exception-pending flag set whenever any exception is taken.
// - illegal encoding is opcode 111111B, sub-opcode 0111B..1111B, bit 16 zero.
// - illegal-opcode trap saves return PC and status into debug save registers.
// - illegal-opcode trap sets nmi, exception pending, irq-disable; jumps to 60H.
// - debug return restores PC and status from debug save registers.
// - debug save registers reachable only from illegal opcode until debug return.
// - debug trap instruction is acknowledged unless an illegal word outranks it.
// - debug trap saves to debug registers, sets three flags, jumps to 60H.
// - after debug trap, debug save registers reachable only until debug return.
// - exceptions taken regardless of the irq-disable flag.
// - exception return with pending flag set does not clear in-service priority bits.
module cteu_unit
    import cteu_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // instruction from the pipeline
    input wire logic insn_valid,
    input wire logic [31:0] insn_word,
    input wire logic trap_insn,
    input wire logic [4:0] trap_vector,
    input wire logic debug_trap_insn,
    input wire logic exception_return_insn,
    input wire logic debug_return_insn,
    input wire logic [31:0] return_pc,
    // interrupt save registers held outside
    input wire logic [31:0] int_saved_pc,
    input wire logic [31:0] int_saved_status,
    // system register access to debug save registers
    input wire logic dbg_wr,
    input wire logic dbg_sel_status,
    input wire logic [31:0] dbg_wdata,
    // program counter and status word
    output logic pc_load,
    output logic [31:0] pc_target,
    output logic [31:0] program_status_word,
    // saved state
    output logic [31:0] exc_saved_pc,
    output logic [31:0] exc_saved_status,
    output logic [31:0] exception_cause_reg,
    output logic [31:0] dbg_saved_pc,
    output logic [31:0] dbg_saved_status,
    output logic dbg_access_open,
    output logic isp_clear_block,
    output logic illegal_opcode_trap
);
    cteu_event_type ev;
    logic ilg;

    logic pc_load_r, pc_load_nxt;
    logic [31:0] pc_target_r, pc_target_nxt;
    logic [31:0] psw_r, psw_nxt;
    logic [31:0] epc_r, epc_nxt;
    logic [31:0] epsw_r, epsw_nxt;
    logic [31:0] ecr_r, ecr_nxt;
    logic [31:0] dpc_r, dpc_nxt;
    logic [31:0] dpsw_r, dpsw_nxt;
    logic dbg_open_r, dbg_open_nxt;
    logic isp_blk_r, isp_blk_nxt;
    logic ilg_r, ilg_nxt;

    cteu_decode u_decode (
        .insn_valid(insn_valid),
        .insn_word(insn_word),
        .trap_insn(trap_insn),
        .debug_trap_insn(debug_trap_insn),
        .exception_return_insn(exception_return_insn),
        .debug_return_insn(debug_return_insn),
        .is_illegal(ilg),
        .event_kind(ev)
    );

    always_comb begin
        pc_load_nxt = 1'b0;
        pc_target_nxt = pc_target_r;
        psw_nxt = psw_r;
        epc_nxt = epc_r;
        epsw_nxt = epsw_r;
        ecr_nxt = ecr_r;
        dpc_nxt = dpc_r;
        dpsw_nxt = dpsw_r;
        dbg_open_nxt = dbg_open_r;
        isp_blk_nxt = 1'b0;
        ilg_nxt = 1'b0;
        // debug save registers writable only while the window is open
        if (dbg_wr && dbg_open_r) begin
            if (dbg_sel_status) begin
                dpsw_nxt = dbg_wdata;
            end else begin
                dpc_nxt = dbg_wdata;
            end
        end
        // no event looks at the irq-disable flag
        case (ev)
            CTEU_EV_SWX: begin
                epc_nxt = return_pc;
                epsw_nxt = psw_r;
                ecr_nxt = {ecr_r[31:16], `CTEU_SWX_CODE_BASE | {11'h000, trap_vector}};
                psw_nxt[`CTEU_PSW_EP_BIT] = 1'b1;
                psw_nxt[`CTEU_PSW_ID_BIT] = 1'b1;
                pc_load_nxt = 1'b1;
                pc_target_nxt = trap_vector[`CTEU_VEC_SPLIT_BIT] ?
                    `CTEU_SWX_HANDLER_HI : `CTEU_SWX_HANDLER_LO;
            end
            CTEU_EV_ILG, CTEU_EV_DBT: begin
                dpc_nxt = return_pc;
                dpsw_nxt = psw_r;
                psw_nxt[`CTEU_PSW_NP_BIT] = 1'b1;
                psw_nxt[`CTEU_PSW_EP_BIT] = 1'b1;
                psw_nxt[`CTEU_PSW_ID_BIT] = 1'b1;
                pc_load_nxt = 1'b1;
                pc_target_nxt = `CTEU_DBG_HANDLER;
                dbg_open_nxt = 1'b1;
                ilg_nxt = (ev == CTEU_EV_ILG);
            end
            CTEU_EV_DEBUG_RETURN_INSN: begin
                pc_load_nxt = 1'b1;
                pc_target_nxt = dpc_r;
                psw_nxt = dpsw_r;
                dbg_open_nxt = 1'b0;
            end
            CTEU_EV_EXCEPTION_RETURN_INSN: begin
                pc_load_nxt = 1'b1;
                if (psw_r[`CTEU_PSW_EP_BIT]) begin
                    pc_target_nxt = epc_r;
                    psw_nxt = epsw_r;
                    isp_blk_nxt = 1'b1;
                end else begin
                    pc_target_nxt = int_saved_pc;
                    psw_nxt = int_saved_status;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pc_load_r <= 1'b0;
            pc_target_r <= 32'h00000000;
            psw_r <= `CTEU_PSW_RESET;
            epc_r <= 32'h00000000;
            epsw_r <= 32'h00000000;
            ecr_r <= 32'h00000000;
            dpc_r <= 32'h00000000;
            dpsw_r <= 32'h00000000;
            dbg_open_r <= 1'b0;
            isp_blk_r <= 1'b0;
            ilg_r <= 1'b0;
        end else if (clk_en) begin
            pc_load_r <= pc_load_nxt;
            pc_target_r <= pc_target_nxt;
            psw_r <= psw_nxt;
            epc_r <= epc_nxt;
            epsw_r <= epsw_nxt;
            ecr_r <= ecr_nxt;
            dpc_r <= dpc_nxt;
            dpsw_r <= dpsw_nxt;
            dbg_open_r <= dbg_open_nxt;
            isp_blk_r <= isp_blk_nxt;
            ilg_r <= ilg_nxt;
        end
    end

    // outputs straight from flops; debug save registers stay readable, only writes are gated
    assign pc_load = pc_load_r;
    assign pc_target = pc_target_r;
    assign program_status_word = psw_r;
    assign exc_saved_pc = epc_r;
    assign exc_saved_status = epsw_r;
    assign exception_cause_reg = ecr_r;
    assign dbg_saved_pc = dpc_r;
    assign dbg_saved_status = dpsw_r;
    assign dbg_access_open = dbg_open_r;
    assign isp_clear_block = isp_blk_r;
    assign illegal_opcode_trap = ilg_r;

    // software exception entry
    chk_swx_vector_lo: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_SWX && !trap_vector[4]
        |=> pc_load && pc_target == 32'h00000040) else $error("low trap vector target");

    chk_swx_vector_hi: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_SWX && trap_vector[4]
        |=> pc_load && pc_target == 32'h00000050) else $error("high trap vector target");

    chk_swx_save_pc: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_SWX |=> exc_saved_pc == $past(return_pc)
        && exc_saved_status == $past(psw_r)) else $error("exception save wrong");

    chk_swx_cause: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_SWX |=> exception_cause_reg[15:0]
        == (16'h0040 | {11'h000, $past(trap_vector)})) else $error("cause code wrong");

    chk_swx_flags: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_SWX |=> program_status_word[6]
        && program_status_word[5]) else $error("ep or id not set");

    chk_swx_ignores_id: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_SWX && psw_r[5]
        |=> pc_load) else $error("trap refused while irq disabled");

    chk_swx_keeps_np: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_SWX
        |=> program_status_word[7] == $past(psw_r[7])) else $error("trap touched nmi pending");

    chk_swx_cause_top: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_SWX
        |=> exception_cause_reg[31:16] == $past(ecr_r[31:16])) else $error("cause top changed");

    // a debug write beside a trap or a return still lands, so leave it out here
    chk_swx_no_dbg: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_SWX && !dbg_wr |=> dbg_saved_pc == $past(dpc_r)
        && !illegal_opcode_trap) else $error("trap hit debug state");

    chk_ep_on_entry: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && (ev == CTEU_EV_SWX || ev == CTEU_EV_ILG || ev == CTEU_EV_DBT)
        |=> program_status_word[6]) else $error("ep not set on entry");

    // debug entry, illegal decode and the debug window
    chk_dbg_entry: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && (ev == CTEU_EV_ILG || ev == CTEU_EV_DBT) |=> pc_target == 32'h00000060
        && program_status_word[7:5] == 3'h7 && dbg_access_open) else $error("debug entry wrong");

    chk_ilg_save: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_ILG |=> dbg_saved_pc == $past(return_pc)
        && illegal_opcode_trap) else $error("illegal trap save wrong");

    chk_ilg_status: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_ILG
        |=> dbg_saved_status == $past(psw_r)) else $error("illegal trap status save wrong");

    chk_ilg_entry: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_ILG |=> pc_load && pc_target == 32'h00000060
        && program_status_word[7:5] == 3'h7) else $error("illegal trap entry wrong");

    chk_ilg_priority: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && insn_valid && ilg
        |=> illegal_opcode_trap && pc_target == 32'h00000060) else $error("illegal decode lost");

    chk_ilg_pulse: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev != CTEU_EV_ILG
        |=> !illegal_opcode_trap) else $error("illegal trap flag stuck");

    chk_dbt_taken: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && insn_valid && debug_trap_insn && !ilg
        |=> pc_load && dbg_access_open) else $error("debug trap refused");

    chk_dbt_save: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_DBT |=> dbg_saved_pc == $past(return_pc)
        && dbg_saved_status == $past(psw_r)) else $error("debug trap save wrong");

    chk_dbg_closed: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && dbg_wr && !dbg_open_r && ev == CTEU_EV_NONE
        |=> $stable(dbg_saved_pc)) else $error("debug reg written while closed");

    chk_dbg_closed_st: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && dbg_wr && !dbg_open_r && ev == CTEU_EV_NONE
        |=> $stable(dbg_saved_status)) else $error("debug status written while closed");

    chk_dbg_write_open: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && dbg_wr && dbg_open_r && !dbg_sel_status && ev == CTEU_EV_NONE
        |=> dbg_saved_pc == $past(dbg_wdata)) else $error("open debug write lost");

    chk_dbg_open_holds: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && dbg_open_r && ev != CTEU_EV_DEBUG_RETURN_INSN
        |=> dbg_access_open) else $error("debug window closed early");

    // returns
    chk_exception_return_insn_restore: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_EXCEPTION_RETURN_INSN && psw_r[6] |=> pc_target == $past(epc_r)
        && program_status_word == $past(epsw_r) && isp_clear_block) else $error("exception_return_insn restore wrong");

    chk_exception_return_insn_int: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_EXCEPTION_RETURN_INSN && !psw_r[6] |=> pc_target == $past(int_saved_pc)
        && program_status_word == $past(int_saved_status)) else $error("int restore wrong");

    chk_isp_only_exception_return_insn: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev != CTEU_EV_EXCEPTION_RETURN_INSN
        |=> !isp_clear_block) else $error("in-service hold without return");

    chk_debug_return_insn_restore: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_DEBUG_RETURN_INSN |=> pc_target == $past(dpc_r)
        && !dbg_access_open) else $error("debug_return_insn restore wrong");

    chk_debug_return_insn_status: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && ev == CTEU_EV_DEBUG_RETURN_INSN
        |=> pc_load && program_status_word == $past(dpsw_r)) else $error("debug_return_insn status wrong");

endmodule

// [dv/cteu_pipe_model.sv]
`timescale 1ns/1ps
module cteu_pipe_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // program counter load from the unit
    input wire logic pc_load,
    input wire logic [31:0] pc_target,
    // pipeline values handed to the unit
    output logic [31:0] return_pc,
    output logic [31:0] int_saved_pc,
    output logic [31:0] int_saved_status
);
    logic [31:0] pc_r;
    // interrupt save registers with the pending flag clear
    assign int_saved_pc = 32'h00000200;
    assign int_saved_status = 32'h00000001;
    assign return_pc = pc_r + 32'h00000004;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pc_r <= 32'h00000100;
        end else if (pc_load) begin
            pc_r <= pc_target;
        end
    end
endmodule

// [dv/cteu_unit_tb.sv]
`timescale 1ns/1ps
`include "cteu_consts.svh"
module cteu_unit_tb;
    logic clock, rst_n, clk_en, insn_valid, trap_insn, debug_trap_insn, ep;
    logic exception_return_insn, debug_return_insn, dbg_wr, dbg_sel_status, pc_load;
    logic isp_clear_block, illegal_opcode_trap, dbg_access_open;
    logic [4:0] trap_vector, v;
    logic [3:0] k;
    logic [31:0] insn_word, dbg_wdata, return_pc, int_saved_pc, int_saved_status, pc_target;
    logic [31:0] program_status_word, exc_saved_pc, exc_saved_status, exception_cause_reg;
    logic [31:0] dbg_saved_pc, dbg_saved_status, w, rp, psw_e, sv_pc, sv_st;
    int failures, cmp_count;
    // word, vector, strobes {trap, debug trap, return, debug return}
    logic [40:0] rows [9] = '{{32'h0, 5'h00, 4'h2}, {32'h0, 5'h00, 4'h8}, {32'h0, 5'h00, 4'h2},
        {32'h0, 5'h0F, 4'h8}, {32'h0, 5'h10, 4'h8}, {32'h0, 5'h1F, 4'h8}, {32'h0, 5'h00, 4'h2},
        {32'h030007E0, 5'h00, 4'h0}, {32'h038107E0, 5'h00, 4'h0}};
    cteu_pipe_model pipe (.clock(clock), .rst_n(rst_n), .pc_load(pc_load),
        .pc_target(pc_target), .return_pc(return_pc), .int_saved_pc(int_saved_pc),
        .int_saved_status(int_saved_status));
    cteu_unit dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .insn_valid(insn_valid),
        .insn_word(insn_word), .trap_insn(trap_insn), .trap_vector(trap_vector),
        .debug_trap_insn(debug_trap_insn), .exception_return_insn(exception_return_insn),
        .debug_return_insn(debug_return_insn), .return_pc(return_pc),
        .int_saved_pc(int_saved_pc), .int_saved_status(int_saved_status), .dbg_wr(dbg_wr),
        .dbg_sel_status(dbg_sel_status), .dbg_wdata(dbg_wdata), .pc_load(pc_load),
        .pc_target(pc_target), .program_status_word(program_status_word),
        .exc_saved_pc(exc_saved_pc), .exc_saved_status(exc_saved_status),
        .exception_cause_reg(exception_cause_reg), .dbg_saved_pc(dbg_saved_pc),
        .dbg_saved_status(dbg_saved_status), .dbg_access_open(dbg_access_open),
        .isp_clear_block(isp_clear_block), .illegal_opcode_trap(illegal_opcode_trap));
    always #4 clock = ~clock;
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // results land on the taking edge and are read just after it
    task automatic op(input logic [31:0] iw, input logic [4:0] iv, input logic [3:0] ik);
        @(posedge clock);
        {insn_valid, trap_insn, debug_trap_insn, exception_return_insn, debug_return_insn} <=
            {1'h1, ik};
        insn_word <= iw;
        trap_vector <= iv;
        #1 rp = return_pc;
        @(posedge clock);
        {insn_valid, trap_insn, debug_trap_insn, exception_return_insn, debug_return_insn} <=
            5'h00;
        #1;
    endtask
    task automatic wr(input logic sel, input logic [31:0] d);
        @(posedge clock);
        {dbg_wr, dbg_sel_status, dbg_wdata} <= {1'h1, sel, d};
        @(posedge clock);
        dbg_wr <= 1'h0;
        #1;
    endtask
    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        give_verdict();
    end
    initial begin
        {clock, rst_n, clk_en, insn_valid, trap_insn, debug_trap_insn} = 6'h08;
        {exception_return_insn, debug_return_insn, dbg_wr, dbg_sel_status} = 4'h0;
        {trap_vector, insn_word, dbg_wdata} = '0;
        repeat (6) @(posedge clock);
        rst_n <= 1'h1;
        #1 psw_e = `CTEU_PSW_RESET;
        chk(program_status_word, psw_e);
        $display("reset test done");
        for (int i = 0; i < 9; i++) begin
            {w, v, k} = rows[i];
            ep = psw_e[`CTEU_PSW_EP_BIT];
            op(w, v, k);
            chk(pc_load, |k);
            chk(illegal_opcode_trap, 1'h0);
            if (k[3]) begin
                chk(pc_target, v[4] ? `CTEU_SWX_HANDLER_HI : `CTEU_SWX_HANDLER_LO);
                chk(exc_saved_pc, rp);
                chk(exc_saved_status, psw_e);
                chk(exception_cause_reg[15:0], `CTEU_SWX_CODE_BASE | v);
                sv_pc = rp;
                sv_st = psw_e;
                psw_e = psw_e | 32'h00000060;
            end
            if (k[1]) begin
                chk(pc_target, ep ? sv_pc : int_saved_pc);
                chk(isp_clear_block, ep);
                psw_e = ep ? sv_st : int_saved_status;
            end
            chk(program_status_word, psw_e);
        end
        $display("row tests done");
        wr(1'h0, 32'h00000300);
        chk(dbg_saved_pc, 32'h00000000);
        op(32'h038007E0, 5'h00, 4'h0);
        chk(illegal_opcode_trap, 1'h1);
        chk(pc_target, `CTEU_DBG_HANDLER);
        chk(dbg_saved_pc, rp);
        chk(dbg_saved_status, psw_e);
        chk(program_status_word, psw_e | 32'h000000E0);
        chk(dbg_access_open, 1'h1);
        wr(1'h0, 32'h00000300);
        wr(1'h1, 32'h00000002);
        chk(dbg_saved_pc, 32'h00000300);
        chk(dbg_saved_status, 32'h00000002);
        for (int j = 0; j < 2; j++) begin
            op(32'h0, 5'h00, 4'h1);
            chk(pc_target, j ? sv_pc : 32'h00000300);
            chk(program_status_word, 32'h00000002);
            chk(dbg_access_open, 1'h0);
            op(32'h0, 5'h00, 4'h4);
            sv_pc = rp;
            chk(pc_target, `CTEU_DBG_HANDLER);
            chk(dbg_saved_pc, rp);
            chk(dbg_saved_status, 32'h00000002);
            chk(program_status_word, 32'h000000E2);
            chk(dbg_access_open, 1'h1);
        end
        op(32'h078007E0, 5'h1F, 4'h8);
        chk(illegal_opcode_trap, 1'h1);
        chk(pc_target, `CTEU_DBG_HANDLER);
        // let the load pulse drop first, else the freeze holds it high
        @(posedge clock);
        clk_en <= 1'h0;
        op(32'h0, 5'h03, 4'h8);
        chk(pc_load, 1'h0);
        chk(pc_target, `CTEU_DBG_HANDLER);
        clk_en <= 1'h1;
        $display("hand tests done");
        @(posedge clock);
        rst_n <= 1'h0;
        @(posedge clock);
        #1;
        chk(program_status_word, `CTEU_PSW_RESET);
        chk(dbg_access_open, 1'h0);
        chk(dbg_saved_pc, 32'h00000000);
        chk(exception_cause_reg, 32'h00000000);
        @(posedge clock);
        rst_n <= 1'h1;
        op(32'h0, 5'h05, 4'h8);
        chk(exc_saved_pc, rp);
        chk(exc_saved_status, `CTEU_PSW_RESET);
        chk(exception_cause_reg, {16'h0000, `CTEU_SWX_CODE_BASE | 16'h0005});
        chk(program_status_word, `CTEU_PSW_RESET | 32'h00000060);
        $display("mid-run reset test done");
        give_verdict();
    end
endmodule
